// file: design/smps_pkg.sv
// Constants and types of the serial memory port with safeload unit
package smps_pkg;
  // Serial address map, 10-bit space
  localparam logic [9:0] PARAM_FIRST  = 10'h000;
  localparam logic [9:0] PARAM_LAST   = 10'h0ff;
  localparam logic [9:0] CTRL1_ADDR   = 10'h100;
  localparam logic [9:0] CTRL2_ADDR   = 10'h101;
  localparam logic [9:0] VOL_FIRST    = 10'h102;
  localparam logic [9:0] VOL_LAST     = 10'h104;
  localparam logic [9:0] CAP_FIRST    = 10'h105;
  localparam logic [9:0] CAP_LAST     = 10'h108;
  localparam logic [9:0] SLOT_FIRST   = 10'h109;
  localparam logic [9:0] SLOT_LAST    = 10'h10d;
  localparam logic [9:0] PROG_FIRST   = 10'h200;
  // Data bytes that follow the header, per word
  localparam logic [2:0] PARAM_BYTES  = 3'h3;
  localparam logic [2:0] PROG_BYTES   = 3'h5;
  localparam logic [2:0] REG_BYTES    = 3'h2;
  localparam logic [2:0] VOL_BYTES    = 3'h3;
  localparam logic [2:0] SLOT_BYTES   = 3'h4;
  localparam logic [2:0] STAT_BYTES   = 3'h1;
  localparam logic [2:0] MAX_BYTES    = 3'h5;
  // Read/write flag position in the first header byte
  localparam int RW_BIT               = 2;
  // Primary control fields
  localparam int DONE_BIT             = 0;
  localparam int HALTED_BIT           = 1;
  localparam int HALT_BIT             = 4;
  localparam int SL_REQ_BIT           = 5;
  // Reset values
  localparam logic [11:0] CTRL1_RST   = 12'h000;
  localparam logic [9:0]  CTRL2_RST   = 10'h000;
  localparam logic [21:0] VOL_RST     = 22'h000000;
  localparam logic [2:0]  SYNC_RST    = 3'h2;
  // Safeload slots
  localparam logic [2:0]  SLOT_LAST_IDX = 3'h4;
  // Capture source select
  typedef enum logic [1:0] {
    SRC_MULT_OUT  = 2'b00,
    SRC_DECIBEL   = 2'b01,
    SRC_MULT_DATA = 2'b10,
    SRC_MULT_COEF = 2'b11
  } smps_src_t;
  typedef struct packed {
    logic [8:0] capture_step_count;
    smps_src_t  capture_source_select;
  } smps_cap_t;
  // One buffered write word
  typedef struct packed {
    logic [9:0]  addr;
    logic [34:0] data;
  } smps_wr_t;
  typedef enum logic [1:0] {
    SL_IDLE = 2'b00,
    SL_WAIT = 2'b01,
    SL_RUN  = 2'b10
  } smps_sl_t;
  typedef enum logic [1:0] {
    PH_HDR0 = 2'b00,
    PH_HDR1 = 2'b01,
    PH_DATA = 2'b10
  } smps_ph_t;
endpackage

// file: design/smps_port.sv
// Serial control port decoder with write buffer and safeload unit
// Operation
// - Five slots, each target address plus word
// - Safeload waits for five idle RAM cycles
// - All staged words written within one gap
// - Done bit set at end, cleared on read
// - Transfer finishes within one audio frame
// - Only slots written since last safeload go
// - Any parameter address may be a target
// - Padding bits to byte boundary are zeros
// - Parameter word 22 bits in three bytes
// - Program word 35 bits in five bytes
// - Two-byte header: flag and 10-bit address
// - Data length follows from address and read flag
// - Single writes four to seven bytes long
// - Burst words go to consecutive addresses in RAM only
// - Both RAMs writable and readable, safeload parameter
// - Primary control write: 12 bits, two bytes
// - Primary control read: one byte, two status
// - Secondary control write: 10 bits, two bytes
// - Volume write 22 bits, no flag
// - Capture setup: step count and source
// - Hold/decay integers, others fractional
// - Halt bit starts ramp-down, bit 1 reports
// - Source select decodes to four operands
// - Slot write: address byte then word
`timescale 1ns/1ns
module smps_port (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      spi_sclk_i,
  input  wire logic                      spi_cs_n_i,
  input  wire logic                      spi_mosi_i,
  output logic                           spi_miso_o,
  output logic                           spi_miso_oe_n_o,
  output logic [9:0]                     ram_addr_o,
  output logic [34:0]                    ram_wdata_o,
  output logic                           ram_we_o,
  input  wire logic [34:0]               ram_rdata_i,
  input  wire logic                      param_gap_i,
  input  wire logic                      core_halted_i,
  output logic [11:0]                    ctrl1_o,
  output logic [9:0]                     ctrl2_o,
  output logic                           halt_req_o,
  output logic [2:0][21:0]               volume_o,
  output smps_pkg::smps_cap_t [1:0]      cap_readback_o,
  output smps_pkg::smps_cap_t [1:0]      cap_serial_o,
  output logic                           safeload_busy_o
);

  // All state of the block
  typedef struct packed {
    logic [2:0]                 s1;       // Sync stage 1: sclk, cs_n, mosi
    logic [2:0]                 s2;       // Sync stage 2
    logic [2:0]                 sp;       // Previous stage 2, edge finding
    smps_pkg::smps_ph_t         ph;       // Byte phase in frame
    logic [2:0]                 bit_cnt;  // Bit within byte
    logic [7:0]                 sh;       // Receive shifter
    logic [2:0]                 byte_cnt; // Byte within word
    logic [39:0]                acc;      // Word collector
    logic                       rd;       // Frame is a read
    logic [9:0]                 addr;     // Current word address
    logic [39:0]                tx;       // Transmit shifter
    logic                       miso;     // Bit on the pin
    logic                       rd_pend;  // Read word wanted
    logic                       rd_wait;  // RAM read in flight
    logic                       hold_v;   // Word waiting for buffer
    smps_pkg::smps_wr_t         hold;     // That word
    smps_pkg::smps_wr_t [1:0]   fifo;     // Two-entry write buffer
    logic                       head;     // Oldest entry
    logic [1:0]                 cnt;      // Entries used
    logic [9:0]                 ram_addr; // Memory port
    logic [34:0]                ram_wdata;
    logic                       ram_we;
    logic [11:0]                ctrl1;    // Primary control
    logic [9:0]                 ctrl2;    // Secondary control
    logic [2:0][21:0]           vol;      // Channel volumes
    smps_pkg::smps_cap_t [1:0]  cap_rd;   // Readable capture setups
    smps_pkg::smps_cap_t [1:0]  cap_so;   // Serial-out capture setups
    logic [4:0][7:0]            sl_addr;  // Slot target addresses
    logic [4:0][21:0]           sl_data;  // Slot data words
    logic [4:0]                 sl_wr;    // Slot written since last run
    smps_pkg::smps_sl_t         sl;       // Safeload state
    logic [2:0]                 sl_idx;   // Slot being applied
    logic                       done;     // Safeload done flag
  } smps_st_t;

  smps_st_t           st;
  smps_st_t           next_st;
  logic               sclk;      // Synced pins
  logic               cs_n;
  logic               mosi;
  logic               rise;      // Sclk edges
  logic               fall;
  logic [7:0]         in_byte;   // Byte being completed
  logic [9:0]         hdr_addr;  // Address at header end
  logic               word_end;  // Last byte of a word taken
  logic               rd_go;     // Read serviced now
  logic               push;      // Hold into buffer
  logic               pop;       // Buffer head applied
  logic               clr_done;  // Status read clears done
  smps_pkg::smps_wr_t w;         // Buffer head
  logic [1:0]         k;         // Register index in a group
  logic [2:0]         s;         // Slot index
  logic [9:0]         sl_target; // Address of current slot

  // RAM addresses: parameter low, program high
  function automatic logic smps_is_ram(input logic [9:0] a);
    return (a <= smps_pkg::PARAM_LAST) || (a >= smps_pkg::PROG_FIRST);
  endfunction

  // Data bytes per word, decided from the address and the read flag
  function automatic logic [2:0] smps_len(input logic [9:0] a, input logic r);
    logic [2:0] n;
    n = smps_pkg::REG_BYTES;
    if (a <= smps_pkg::PARAM_LAST) begin
      n = smps_pkg::PARAM_BYTES;
    end else if (a >= smps_pkg::PROG_FIRST) begin
      n = smps_pkg::PROG_BYTES;
    end else if (a == smps_pkg::CTRL1_ADDR && r) begin
      n = smps_pkg::STAT_BYTES;
    end else if (a >= smps_pkg::VOL_FIRST && a <= smps_pkg::VOL_LAST) begin
      n = smps_pkg::VOL_BYTES;
    end else if (a >= smps_pkg::SLOT_FIRST && a <= smps_pkg::SLOT_LAST) begin
      n = smps_pkg::SLOT_BYTES;
    end
    return n;
  endfunction

  // Right-pad a word so its top data byte leaves first
  function automatic logic [39:0] smps_align(input logic [34:0] d, input logic [2:0] n);
    return {5'h00, d} << {smps_pkg::MAX_BYTES - n, 3'h0};
  endfunction

  // Next state
  always_comb begin
    next_st   = st;
    next_st.ram_we = 1'b0;
    word_end  = 1'b0;
    clr_done  = 1'b0;
    k         = 2'h0;
    s         = 3'h0;
    // Two flops on every pin; only stage 2 is looked at
    next_st.s1 = {spi_sclk_i, spi_cs_n_i, spi_mosi_i};
    next_st.s2 = st.s1;
    next_st.sp = st.s2;
    sclk      = st.s2[2];
    cs_n      = st.s2[1];
    mosi      = st.s2[0];
    rise      = sclk & ~st.sp[2];
    fall      = ~sclk & st.sp[2];
    in_byte   = {st.sh[6:0], mosi};
    hdr_addr  = {st.addr[9:8], in_byte};
    sl_target = {2'b00, st.sl_addr[st.sl_idx]};

    // Read service; a safeload run has the memory port first
    rd_go = st.rd_pend && !st.rd_wait && (st.sl != smps_pkg::SL_RUN);
    if (rd_go) begin
      next_st.rd_pend = 1'b0;
      if (smps_is_ram(st.addr)) begin
        next_st.ram_addr = st.addr;
        next_st.rd_wait  = 1'b1;
      end else if (st.addr == smps_pkg::CTRL1_ADDR) begin
        // Six zeros then halted and done
        next_st.tx = smps_align({33'h0, core_halted_i, st.done},
                                smps_pkg::STAT_BYTES);
        clr_done   = 1'b1;
      end else begin
        // Write-only registers read as zeros
        next_st.tx = 40'h0000000000;
      end
    end
    if (st.rd_wait) begin
      next_st.rd_wait = 1'b0;
      next_st.tx = smps_align(ram_rdata_i, smps_len(st.addr, 1'b1));
    end

    // Buffer fill from the hold register
    push = st.hold_v && (st.cnt != 2'h2);
    if (push) begin
      next_st.fifo[st.head ^ st.cnt[0]] = st.hold;
      next_st.hold_v = 1'b0;
    end

    // Serial byte engine
    if (cs_n) begin
      // Frame ended: drop any partial word
      next_st.ph      = smps_pkg::PH_HDR0;
      next_st.bit_cnt = 3'h0;
      next_st.rd_pend = 1'b0;
      next_st.tx      = 40'h0000000000;
      next_st.miso    = 1'b0;
    end else if (rise) begin
      next_st.sh      = in_byte;
      next_st.bit_cnt = st.bit_cnt + 3'h1;
      if (st.bit_cnt == 3'h7) begin
        case (st.ph)
          smps_pkg::PH_HDR0: begin
            // Five zeros, flag, address 9:8
            next_st.rd   = in_byte[smps_pkg::RW_BIT];
            next_st.addr = {in_byte[1:0], 8'h00};
            next_st.ph   = smps_pkg::PH_HDR1;
          end
          smps_pkg::PH_HDR1: begin
            next_st.addr     = hdr_addr;
            next_st.ph       = smps_pkg::PH_DATA;
            next_st.byte_cnt = 3'h0;
            next_st.acc      = 40'h0000000000;
            // Volume headers carry no flag: always a write
            if (hdr_addr >= smps_pkg::VOL_FIRST && hdr_addr <= smps_pkg::VOL_LAST) begin
              next_st.rd = 1'b0;
            end else begin
              next_st.rd_pend = st.rd;
            end
          end
          smps_pkg::PH_DATA: begin
            next_st.acc = {st.acc[31:0], in_byte};
            if (st.byte_cnt == smps_len(st.addr, st.rd) - 3'h1) begin
              word_end         = 1'b1;
              next_st.byte_cnt = 3'h0;
              if (!st.rd) begin
                next_st.hold_v = 1'b1;
                next_st.hold   = '{st.addr, {st.acc[26:0], in_byte}};
              end
              next_st.rd_pend = st.rd;
              if (smps_is_ram(st.addr)) begin
                next_st.addr = st.addr + 10'h001;
              end
            end else begin
              next_st.byte_cnt = st.byte_cnt + 3'h1;
            end
          end
          default: begin
            next_st.ph = smps_pkg::PH_HDR0;
          end
        endcase
      end
    end else if (fall) begin
      // Output changes on falling edge, MSB first
      next_st.miso = st.tx[39];
      next_st.tx   = {st.tx[38:0], 1'b0};
    end

    // Buffer drain; stalls while the safeload owns the port
    pop = (st.cnt != 2'h0) && (st.sl != smps_pkg::SL_RUN) && !rd_go;
    w   = st.fifo[st.head];
    if (pop) begin
      next_st.head = ~st.head;
      // Padding bits above each field are dropped
      if (smps_is_ram(w.addr)) begin
        // Direct write; words pass bit-exact, the datapath decides
        // integer or fractional meaning
        next_st.ram_we    = 1'b1;
        next_st.ram_addr  = w.addr;
        next_st.ram_wdata = (w.addr >= smps_pkg::PROG_FIRST) ? w.data
                            : {13'h0000, w.data[21:0]};
      end else if (w.addr == smps_pkg::CTRL1_ADDR) begin
        next_st.ctrl1 = w.data[11:0];
      end else if (w.addr == smps_pkg::CTRL2_ADDR) begin
        next_st.ctrl2 = w.data[9:0];
      end else if (w.addr >= smps_pkg::VOL_FIRST && w.addr <= smps_pkg::VOL_LAST) begin
        k = 2'(w.addr - smps_pkg::VOL_FIRST);
        next_st.vol[k] = w.data[21:0];
      end else if (w.addr >= smps_pkg::CAP_FIRST && w.addr <= smps_pkg::CAP_LAST) begin
        k = 2'(w.addr - smps_pkg::CAP_FIRST);
        // Count 8:0 above select 1:0
        if (k[1]) begin
          next_st.cap_so[k[0]] = smps_pkg::smps_cap_t'(w.data[10:0]);
        end else begin
          next_st.cap_rd[k[0]] = smps_pkg::smps_cap_t'(w.data[10:0]);
        end
      end else if (w.addr >= smps_pkg::SLOT_FIRST && w.addr <= smps_pkg::SLOT_LAST) begin
        s = 3'(w.addr - smps_pkg::SLOT_FIRST);
        next_st.sl_addr[s] = w.data[31:24];
        next_st.sl_data[s] = w.data[21:0];
        next_st.sl_wr[s]   = 1'b1;
      end
      // Unmapped addresses are ignored
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};

    // Done flag: read clears, completion sets and wins
    if (clr_done) begin
      next_st.done = 1'b0;
    end

    // Safeload sequencer
    case (st.sl)
      smps_pkg::SL_IDLE: begin
        if (st.ctrl1[smps_pkg::SL_REQ_BIT]) begin
          next_st.sl = smps_pkg::SL_WAIT;
        end
      end
      smps_pkg::SL_WAIT: begin
        // Gap flag means five idle RAM cycles start now; the
        // program has one each frame, which bounds the wait
        if (param_gap_i) begin
          next_st.sl     = smps_pkg::SL_RUN;
          next_st.sl_idx = 3'h0;
        end
      end
      smps_pkg::SL_RUN: begin
        // One slot per clock, five clocks inside the gap
        if (st.sl_wr[st.sl_idx]) begin
          next_st.ram_we    = 1'b1;
          next_st.ram_addr  = sl_target;
          next_st.ram_wdata = {13'h0000, st.sl_data[st.sl_idx]};
        end
        if (st.sl_idx == smps_pkg::SLOT_LAST_IDX) begin
          next_st.sl    = smps_pkg::SL_IDLE;
          next_st.sl_wr = 5'h00;
          next_st.ctrl1[smps_pkg::SL_REQ_BIT] = 1'b0;
          next_st.done  = 1'b1;
        end else begin
          next_st.sl_idx = st.sl_idx + 3'h1;
        end
      end
      default: begin
        next_st.sl = smps_pkg::SL_IDLE;
      end
    endcase
  end

  // State register, synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st       <= '0;
      st.s1    <= smps_pkg::SYNC_RST;
      st.s2    <= smps_pkg::SYNC_RST;
      st.sp    <= smps_pkg::SYNC_RST;
      st.ctrl1 <= smps_pkg::CTRL1_RST;
      st.ctrl2 <= smps_pkg::CTRL2_RST;
      st.vol   <= {3{smps_pkg::VOL_RST}};
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign spi_miso_o      = st.miso;
  assign spi_miso_oe_n_o = st.s2[1];
  assign ram_addr_o      = st.ram_addr;
  assign ram_wdata_o     = st.ram_wdata;
  assign ram_we_o        = st.ram_we;
  assign ctrl1_o         = st.ctrl1;
  assign ctrl2_o         = st.ctrl2;
  // Ramp-down and shutdown run in the core; halted comes back
  assign halt_req_o      = st.ctrl1[smps_pkg::HALT_BIT];
  assign volume_o        = st.vol;
  assign cap_readback_o  = st.cap_rd;
  assign cap_serial_o    = st.cap_so;
  assign safeload_busy_o = st.sl != smps_pkg::SL_IDLE;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start;
    st.sl == smps_pkg::SL_WAIT && param_gap_i;
  endsequence
  sequence s_last;
    st.sl == smps_pkg::SL_RUN && st.sl_idx == smps_pkg::SLOT_LAST_IDX;
  endsequence

  property p_wait_gap;
    st.sl == smps_pkg::SL_WAIT && !param_gap_i |=> st.sl == smps_pkg::SL_WAIT;
  endproperty
  a_wait_gap: assert property (p_wait_gap) else $error("safeload left wait without gap");

  property p_run_len;
    s_start |=> (st.sl == smps_pkg::SL_RUN) [*5] ##1 st.sl == smps_pkg::SL_IDLE;
  endproperty
  a_run_len: assert property (p_run_len) else $error("safeload run not five cycles");

  property p_done_set;
    s_last |=> st.done && safeload_busy_o == 1'b0;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done not set at end");

  property p_done_clr;
    // Completion in the same cycle would win, so it is left out
    rd_go && st.addr == smps_pkg::CTRL1_ADDR
      && !(st.sl == smps_pkg::SL_RUN && st.sl_idx == smps_pkg::SLOT_LAST_IDX)
      |=> !st.done;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared by read");

  property p_req_clr;
    s_last |=> !ctrl1_o[smps_pkg::SL_REQ_BIT] && st.sl_wr == 5'h00;
  endproperty
  a_req_clr: assert property (p_req_clr) else $error("request or flags not cleared");

  property p_skip;
    st.sl == smps_pkg::SL_RUN && !st.sl_wr[st.sl_idx] |=> !ram_we_o;
  endproperty
  a_skip: assert property (p_skip) else $error("unwritten slot applied");

  property p_slot_addr;
    st.sl == smps_pkg::SL_RUN && st.sl_wr[st.sl_idx]
      |=> ram_we_o && ram_addr_o == $past(sl_target);
  endproperty
  a_slot_addr: assert property (p_slot_addr) else $error("slot written to wrong address");

  property p_burst;
    word_end && smps_is_ram(st.addr) |=> st.addr == $past(st.addr) + 10'h001;
  endproperty
  a_burst: assert property (p_burst) else $error("burst address not incremented");

  property p_oe;
    spi_cs_n_i [*4] |-> spi_miso_oe_n_o;
  endproperty
  a_oe: assert property (p_oe) else $error("miso driven outside frame");
endmodule

// file: sim/smps_host_model.sv
// Host-side serial master model of the control port
`timescale 1ns/1ns
module smps_host_model (
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o,
  input  wire logic spi_miso_i
);
  // Idle: clock still and low, deselected
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  // One frame of n bytes from tx[8n-1:0], MSB first, mode 0
  task automatic frame(input logic [127:0] tx, input int n, output logic [127:0] rx);
    rx = '0;
    spi_cs_n_o = 1'b0;
    for (int i = n * 8 - 1; i >= 0; i--) begin
      spi_mosi_o = tx[i];
      #160 spi_sclk_o = 1'b1;
      rx[i] = spi_miso_i;
      #160 spi_sclk_o = 1'b0;
    end
    #160 spi_cs_n_o = 1'b1;
    // Released line must not keep the last bit
    spi_mosi_o = ~spi_mosi_o;
    #480;
  endtask
endmodule

// file: sim/tb_spi_memory_port_safeload.sv
// Self-checking bench of the serial port with safeload unit
`timescale 1ns/1ns
module tb_spi_memory_port_safeload;
  logic clk_i, rst_i, sclk, cs_n, mosi, miso, oe_n, we, gap, halted, busy, halt_req;
  logic [9:0]  addr, ctrl2;
  logic [34:0] wdata, rdata;
  logic [11:0] ctrl1;
  logic [2:0][21:0] volume;
  smps_pkg::smps_cap_t [1:0] cap_rb, cap_so;
  logic [34:0]  mem [0:1023]; // Memory behind the port
  logic [127:0] rx;
  logic [31:0]  we0;
  int fail_count, compares, we_count, cycles;
  smps_port i_smps_port (.clk_i(clk_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n), .ram_addr_o(addr),
    .ram_wdata_o(wdata), .ram_we_o(we), .ram_rdata_i(rdata), .param_gap_i(gap),
    .core_halted_i(halted), .ctrl1_o(ctrl1), .ctrl2_o(ctrl2), .halt_req_o(halt_req),
    .volume_o(volume), .cap_readback_o(cap_rb), .cap_serial_o(cap_so), .safeload_busy_o(busy));
  smps_host_model i_smps_host_model (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
    .spi_miso_i(miso));
  // 40 ns core clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  assign rdata = mem[addr];
  // Memory writes, pulse count, hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (we) begin
      mem[addr] <= wdata;
      we_count++;
    end
    if (cycles > 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic xfer(input logic [127:0] tx, input int n);
    i_smps_host_model.frame(tx, n, rx);
    tick(1);
  endtask
  // Burst words land on consecutive addresses and read back
  task automatic t_param();
    xfer(64'h00102abcde112233, 8);
    check(mem[10'h010], 35'h2abcde);
    check(mem[10'h011], 35'h112233);
    xfer(64'h0410000000000000, 8);
    check(rx[47:0], 48'h2abcde112233);
    xfer(56'h02000512345678, 7);
    check(mem[10'h200], 35'h512345678);
    xfer(56'h06000000000000, 7);
    check(rx[39:0], 40'h0512345678);
  endtask
  // Registers, unmapped address, halt and status read
  task automatic t_regs();
    xfer(32'h010102a5, 4);
    check(ctrl2, 10'h2a5);
    xfer(40'h01022aaaa5, 5);
    check(volume[0], 22'h2aaaa5);
    // Set flag bit in a volume header must still write
    xfer(40'h05033c0f0f, 5);
    check(volume[1], 22'h3c0f0f);
    for (int s = 0; s < 4; s++) begin
      xfer({16'h0106, 8'h05, 6'h15, 2'(s)}, 4);
      check(cap_rb[1], {9'h155, 2'(s)});
    end
    xfer(32'h010703cd, 4);
    check(cap_so[0], {9'h0f3, 2'b01});
    we0 = we_count;
    xfer(32'h0110ffff, 4);
    check(we_count, we0);
    check(ctrl2, 10'h2a5);
    check(ctrl2[9], 1'b1);
    xfer(32'h01000a10, 4);
    check(ctrl1, 12'ha10);
    check(halt_req, 1'b1);
    halted = 1'b1;
    xfer(24'h050000, 3);
    check(rx[7:0], 8'h02);
    halted = 1'b0;
  endtask
  // Two of five slots staged, held until the gap
  task automatic t_safeload();
    xfer(48'h010930155aa5, 6);
    xfer(48'h010bf03c0f0f, 6);
    we0 = we_count;
    xfer(32'h01000020, 4);
    tick(20);
    check(busy, 1'b1);
    check(we_count, we0);
    gap = 1'b1;
    tick(1);
    gap = 1'b0;
    tick(8);
    check(we_count - we0, 2);
    check(mem[10'h030], 35'h155aa5);
    check(mem[10'h0f0], 35'h3c0f0f);
    check({busy, ctrl1[5]}, 2'b00);
    xfer(24'h050000, 3);
    check(rx[7:0], 8'h01);
    xfer(24'h050000, 3);
    check(rx[7:0], 8'h00);
    we0 = we_count;
    xfer(32'h01000020, 4);
    gap = 1'b1;
    tick(1);
    gap = 1'b0;
    tick(8);
    check(we_count, we0);
  endtask
  initial begin
    foreach (mem[i]) mem[i] = '0;
    {fail_count, compares, we_count, cycles} = '0;
    rst_i = 1'b1;
    gap = 1'b0;
    halted = 1'b0;
    tick(8);
    check({oe_n, ctrl1, busy}, 14'h2000);
    rst_i = 1'b0;
    tick(3);
    t_param();
    t_regs();
    t_safeload();
    complete_run();
  end
endmodule
